/* logic/ep0_core.sv */
// Endpoint 0 control core: host token side, FIFO and control/status bits
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ep0_core
  import ep0_pkg::*;
(
  // Clock and reset
  input  wire logic       I_REF_CLK,
  input  wire logic       I_RST_B,
  // Controller link
  ep0_link_if.dev         LINK,
  // Host tokens and received data
  input  wire logic       I_TOK_VALID,
  input  wire logic [1:0] I_TOK_PID,
  input  wire logic       I_RX_VALID,
  input  wire logic [7:0] I_RX_DATA,
  input  wire logic       I_RX_END,
  // Handshake, transmitted data and function address
  output logic            O_HS_VALID,
  output logic [1:0]      O_HS_CODE,
  output logic            O_TX_VALID,
  output logic [7:0]      O_TX_DATA,
  output logic            O_TX_END,
  output logic [6:0]      O_FUNC_ADDR
);

  typedef enum logic [1:0] {RXK_SETUP = 2'h0, RXK_DATA = 2'h1, RXK_STATUS = 2'h2} ep0_rxk_e;

  typedef struct packed {
    logic [12:0]           s1;       // pin synchroniser, first stage
    logic [12:0]           s2;       // pin synchroniser, second stage
    ep0_mode_e             mode;
    logic [7:0]            csr;
    logic                  dec_pend; // request loaded, not yet serviced
    logic                  rx_on;
    ep0_rxk_e              rx_kind;
    logic [6:0]            cnt;
    logic [EP0_MPS-1:0][7:0] mem;
    logic [6:0]            wp;
    logic [6:0]            rp;
    logic                  sending;
    logic                  stat_in;  // zero-length status reply
    logic [6:0]            rx_count;
    logic [6:0]            function_address_reg;
    logic                  intr;
    logic                  hs_v;
    ep0_hs_e               hs_code;
    logic                  tx_v;
    logic [7:0]            tx_data;
    logic                  tx_end;
  } ep0_core_s;

  ep0_core_s  q;
  ep0_core_s  d;
  logic       tok;
  ep0_pid_e   pid;
  logic       bv;
  logic [7:0] bd;
  logic       be;
  logic       do_stall;
  logic       do_prem;
  logic       in_dir;
  logic       has_data;

  // ------------------------------------------------------------------
  // Synchronised host inputs and request decode
  // ------------------------------------------------------------------
  assign tok      = q.s2[12];
  assign pid      = ep0_pid_e'(q.s2[11:10]);
  assign bv       = q.s2[9];
  assign bd       = q.s2[8:1];
  assign be       = q.s2[0];
  assign in_dir   = q.mem[EP0_REQ_TYPE][EP0_DIR_BIT];
  assign has_data = |{q.mem[EP0_WLEN_HI], q.mem[EP0_WLEN_LO]};

  // ------------------------------------------------------------------
  // Next state: controller effects first, host events after so host events win
  // ------------------------------------------------------------------
  always_comb
  begin
    d         = q;
    do_stall  = 1'b0;
    do_prem   = 1'b0;
    d.s1      = {I_TOK_VALID, I_TOK_PID, I_RX_VALID, I_RX_DATA, I_RX_END};
    d.s2      = q.s1;
    d.intr    = 1'b0;
    d.hs_v    = 1'b0;
    d.tx_v    = 1'b0;
    d.tx_end  = 1'b0;
    // Controller writes to ep0_control_status
    if (LINK.csr_wr)
    begin
      if (LINK.csr_wdata[B_SSENT]) d.csr[B_SSENT] = 1'b0; // write one clears
      if (LINK.csr_wdata[B_PCLR])  d.csr[B_PEND]  = 1'b0;
      if (LINK.csr_wdata[B_SREQ])  d.csr[B_SREQ]  = 1'b1;
      if (LINK.csr_wdata[B_DEND])  d.csr[B_DEND]  = 1'b1;
      if (LINK.csr_wdata[B_TXR])
      begin
        d.csr[B_TXR] = 1'b1;
        d.rp         = '0;
      end
      if (LINK.csr_wdata[B_SERV])
      begin
        d.csr[B_RXR] = 1'b0;
        d.wp         = '0;
        d.rp         = '0;
        if (q.dec_pend)
        begin
          d.dec_pend = 1'b0;
          // Direction is taken from the command, not from the CPU
          if (has_data && !LINK.csr_wdata[B_SREQ] && !LINK.csr_wdata[B_DEND])
            d.mode = in_dir ? MODE_TX : MODE_RX;
        end
      end
    end
    // Controller FIFO access; the pointers never pass each other
    if (LINK.fifo_wr && q.wp < EP0_MPS)
    begin
      d.mem[q.wp[5:0]] = LINK.fifo_wdata;
      d.wp             = q.wp + 7'h01;
    end
    if (LINK.fifo_rd && q.rp < q.wp)
      d.rp = q.rp + 7'h01;
    if (LINK.function_address_reg_wr)
      d.function_address_reg = LINK.function_address_reg;
    // Transmission of the loaded packet or of a zero-length status reply
    if (q.sending)
    begin
      if (q.rp != q.wp)
      begin
        d.tx_v    = 1'b1;
        d.tx_data = q.mem[q.rp[5:0]];
        d.rp      = q.rp + 7'h01;
      end
      else
      begin
        d.tx_end  = 1'b1;
        d.sending = 1'b0;
        d.intr    = 1'b1;
        d.wp      = '0;
        d.rp      = '0;
        if (q.stat_in)
        begin
          d.mode         = MODE_IDLE;
          d.csr[B_DEND]  = 1'b0;
        end
        else
          d.csr[B_TXR]   = 1'b0;
      end
    end
    else if (tok)
    begin
      case (pid)
        PID_SETUP:
        begin
          // A new request while a transfer is still open ends it early
          if (q.csr[B_TXR] || (q.mode != MODE_IDLE && !q.csr[B_DEND]))
            do_prem = 1'b1;
          d.mode        = MODE_IDLE;
          d.csr[B_RXR]  = 1'b0;
          d.csr[B_TXR]  = 1'b0;
          d.csr[B_DEND] = 1'b0;
          d.csr[B_SREQ] = 1'b0;
          d.dec_pend    = 1'b0;
          d.rx_on       = 1'b1;
          d.rx_kind     = RXK_SETUP;
          d.cnt         = '0;
          d.wp          = '0;
          d.rp          = '0;
        end
        PID_OUT:
        begin
          if (q.csr[B_SREQ] || (q.csr[B_DEND] && q.mode != MODE_TX))
            do_stall = 1'b1;
          else if (q.mode == MODE_TX)
          begin
            if (q.csr[B_DEND] && !q.csr[B_TXR])
            begin
              d.rx_on   = 1'b1;
              d.rx_kind = RXK_STATUS;
              d.cnt     = '0;
            end
            else
              do_prem = 1'b1;
          end
          else if (q.mode == MODE_RX && !q.csr[B_RXR])
          begin
            d.rx_on   = 1'b1;
            d.rx_kind = RXK_DATA;
            d.cnt     = '0;
            d.wp      = '0;
            d.rp      = '0;
          end
          else
          begin
            d.hs_v    = 1'b1;
            d.hs_code = HS_NAK;
          end
        end
        PID_IN:
        begin
          if (q.csr[B_SREQ] || (q.mode == MODE_TX && q.csr[B_DEND] && !q.csr[B_TXR]))
            do_stall = 1'b1;
          else if (q.mode == MODE_TX && q.csr[B_TXR])
          begin
            d.sending = 1'b1;
            d.stat_in = 1'b0;
          end
          else if (q.mode == MODE_RX && !q.csr[B_DEND])
            do_prem = 1'b1;
          else if (q.mode != MODE_TX && q.csr[B_DEND] && !q.csr[B_RXR])
          begin
            d.sending = 1'b1;
            d.stat_in = 1'b1;
            d.wp      = '0;
            d.rp      = '0;
          end
          else
          begin
            d.hs_v    = 1'b1;
            d.hs_code = HS_NAK;
          end
        end
        default:
        begin
          d.hs_v = 1'b0;
        end
      endcase
    end
    // Collection of SETUP, OUT data and status bytes
    else if (q.rx_on && bv)
    begin
      if (q.cnt < EP0_MPS)
        d.mem[q.cnt[5:0]] = bd;
      if (q.cnt != EP0_CNT_SAT)
        d.cnt = q.cnt + 7'h01;
    end
    else if (q.rx_on && be)
    begin
      d.rx_on = 1'b0;
      case (q.rx_kind)
        RXK_SETUP:
        begin
          // A command of any other length is dropped without an answer
          if (q.cnt == EP0_SETUP_LEN)
          begin
            d.csr[B_RXR] = 1'b1;
            d.intr       = 1'b1;
            d.dec_pend   = 1'b1;
            d.wp         = q.cnt;
            d.hs_v       = 1'b1;
            d.hs_code    = HS_ACK;
          end
        end
        RXK_DATA:
        begin
          if (q.cnt > EP0_MPS)
            do_stall = 1'b1;
          else
          begin
            d.csr[B_RXR] = 1'b1;
            d.rx_count   = q.cnt;
            d.wp         = q.cnt;
            d.intr       = 1'b1;
            d.hs_v       = 1'b1;
            d.hs_code    = HS_ACK;
          end
        end
        RXK_STATUS:
        begin
          if (q.cnt == 7'h00)
          begin
            d.mode        = MODE_IDLE;
            d.csr[B_DEND] = 1'b0;
            d.intr        = 1'b1;
            d.hs_v        = 1'b1;
            d.hs_code     = HS_ACK;
          end
          else
            do_stall = 1'b1;          // non-empty status packet
        end
        default:
        begin
          d.rx_on = 1'b0;
        end
      endcase
    end
    // Shared outcomes of a STALL and of an early end
    if (do_stall)
    begin
      d.csr[B_SSENT] = 1'b1;
      d.csr[B_SREQ]  = 1'b0;
      d.csr[B_DEND]  = 1'b0;
      d.csr[B_TXR]   = 1'b0;
      d.mode         = MODE_IDLE;
      d.intr         = 1'b1;
      d.hs_v         = 1'b1;
      d.hs_code      = HS_STALL;
    end
    if (do_prem)
    begin
      d.csr[B_PEND]  = 1'b1;
      d.csr[B_TXR]   = 1'b0;
      d.mode         = MODE_IDLE;
      d.intr         = 1'b1;
      d.hs_v         = 1'b1;
      d.hs_code      = HS_NAK;
    end
  end

  // ------------------------------------------------------------------
  // State register; reset leaves the endpoint in IDLE
  // ------------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_B)
      q <= '0;
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign O_HS_VALID      = q.hs_v;
  assign O_HS_CODE       = q.hs_code;
  assign O_TX_VALID      = q.tx_v;
  assign O_TX_DATA       = q.tx_data;
  assign O_TX_END        = q.tx_end;
  assign O_FUNC_ADDR     = q.function_address_reg;
  assign LINK.csr_rdata  = q.csr;
  assign LINK.ep0_int    = q.intr;
  assign LINK.fifo_rdata = q.mem[q.rp[5:0]];
  assign LINK.rx_count   = q.rx_count;

endmodule : ep0_core
`default_nettype wire

/* logic/ep0_ctl.sv */
// Endpoint 0 controlling logic: AXI4-Lite registers driving the core link
`timescale 1ns/1ps
`default_nettype none
module ep0_ctl
  import ep0_pkg::*;
(
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST_B,
  // AXI4-Lite write channels
  input  wire logic        I_AWVALID,
  input  wire logic [7:0]  I_AWADDR,
  output logic             O_AWREADY,
  input  wire logic        I_WVALID,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  output logic             O_WREADY,
  output logic             O_BVALID,
  output logic [1:0]       O_BRESP,
  input  wire logic        I_BREADY,
  // AXI4-Lite read channels
  input  wire logic        I_ARVALID,
  input  wire logic [7:0]  I_ARADDR,
  output logic             O_ARREADY,
  output logic             O_RVALID,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  input  wire logic        I_RREADY,
  // Core link
  ep0_link_if.ctl          LINK
);

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic        awready;
    logic        wready;
    logic        arready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        csr_wr;
    logic [7:0]  csr_wdata;
    logic        fifo_rd;
    logic        fifo_wr;
    logic [7:0]  fifo_wdata;
    logic        function_address_reg_wr;
    logic [6:0]  function_address_reg;
    ep0_mode_e   mode;
    logic        evt;
    logic        pclr_pend;
    logic [6:0]  load_cnt;
  } ep0_ctl_s;

  ep0_ctl_s q;
  ep0_ctl_s d;

  // ------------------------------------------------------------------
  // Bus slave, link strobes and endpoint mode
  // ------------------------------------------------------------------
  always_comb
  begin
    d          = q;
    d.csr_wr   = 1'b0;
    d.fifo_rd  = 1'b0;
    d.fifo_wr  = 1'b0;
    d.function_address_reg_wr = 1'b0;
    if (I_AWVALID && q.awready)
    begin
      d.aw_got = 1'b1;
      d.awaddr = I_AWADDR;
    end
    if (I_WVALID && q.wready)
    begin
      d.w_got = 1'b1;
      d.wdata = I_WDATA;
    end
    if (q.bvalid && I_BREADY)
      d.bvalid = 1'b0;
    if (q.rvalid && I_RREADY)
      d.rvalid = 1'b0;
    // Write takes effect once address and data are both held
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      case (q.awaddr)
        A_CMD:
        begin
          // One write carries every bit together, e.g. serviced plus last
          d.csr_wr    = 1'b1;
          d.csr_wdata = q.wdata[7:0];
          d.mode      = ep0_mode_e'(q.wdata[F_MODE_HI:F_MODE_LO]);
          if (q.wdata[B_TXR])
            d.load_cnt = '0;
        end
        A_FIFO:
        begin
          // A packet larger than max_packet_size is refused byte by byte
          if (q.load_cnt < EP0_MPS)
          begin
            d.fifo_wr    = 1'b1;
            d.fifo_wdata = q.wdata[7:0];
            d.load_cnt   = q.load_cnt + 7'h01;
          end
          else
            d.bresp = RESP_SLVERR;
        end
        A_FUNCTION_ADDRESS_REG:
        begin
          d.function_address_reg_wr = 1'b1;
          d.function_address_reg    = q.wdata[6:0];
        end
        A_STAT:
        begin
          if (q.wdata[F_EVT])
            d.evt = 1'b0;
        end
        default:
        begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Read answers one cycle after the address is taken
    if (I_ARVALID && q.arready)
    begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
      case (I_ARADDR)
        A_STAT:
          d.rdata = {21'h000000, q.evt, q.mode, LINK.csr_rdata};
        A_FIFO:
        begin
          d.rdata   = {24'h000000, LINK.fifo_rdata};
          d.fifo_rd = 1'b1;
        end
        A_CNT:
          d.rdata = {25'h0000000, LINK.rx_count};
        default:
          d.rresp = RESP_SLVERR;
      endcase
    end
    // Interrupt: sticky event, abort on stall or early end
    if (LINK.ep0_int)
    begin
      d.evt = 1'b1;                   // set wins over a clear
      if (LINK.csr_rdata[B_SSENT] || LINK.csr_rdata[B_PEND])
        d.mode = MODE_IDLE;
      if (LINK.csr_rdata[B_PEND])
        d.pclr_pend = 1'b1;
    end
    // The flag clear waits for a free cycle on the link
    if (q.pclr_pend && !d.csr_wr)
    begin
      d.csr_wr    = 1'b1;
      d.csr_wdata = CSR_PCLR_ONLY;
      d.pclr_pend = 1'b0;
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;
    d.arready = !d.rvalid && !(I_ARVALID && q.arready);
  end

  // ------------------------------------------------------------------
  // State register; controller starts in IDLE
  // ------------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_B)
      q <= '0;
    else
      q <= d;
  end

  assign O_AWREADY       = q.awready;
  assign O_WREADY        = q.wready;
  assign O_BVALID        = q.bvalid;
  assign O_BRESP         = q.bresp;
  assign O_ARREADY       = q.arready;
  assign O_RVALID        = q.rvalid;
  assign O_RDATA         = q.rdata;
  assign O_RRESP         = q.rresp;
  assign LINK.csr_wr     = q.csr_wr;
  assign LINK.csr_wdata  = q.csr_wdata;
  assign LINK.fifo_rd    = q.fifo_rd;
  assign LINK.fifo_wr    = q.fifo_wr;
  assign LINK.fifo_wdata = q.fifo_wdata;
  assign LINK.function_address_reg_wr   = q.function_address_reg_wr;
  assign LINK.function_address_reg      = q.function_address_reg;

endmodule : ep0_ctl
`default_nettype wire

/* logic/ep0_link_if.sv */
// Link between the endpoint 0 core and its controlling logic
`timescale 1ns/1ps
`default_nettype none
interface ep0_link_if;
  logic       csr_wr;     // one-cycle write of ep0_control_status
  logic [7:0] csr_wdata;
  logic [7:0] csr_rdata;  // current ep0_control_status
  logic       ep0_int;    // one-cycle endpoint 0 interrupt
  logic       fifo_rd;    // pop one byte
  logic [7:0] fifo_rdata; // byte at the head of the FIFO
  logic       fifo_wr;    // push one byte
  logic [7:0] fifo_wdata;
  logic [6:0] rx_count;   // ep0_rx_byte_count
  logic       function_address_reg_wr;   // write function_address_reg
  logic [6:0] function_address_reg;

  modport dev (input csr_wr, csr_wdata, fifo_rd, fifo_wr, fifo_wdata, function_address_reg_wr, function_address_reg,
               output csr_rdata, ep0_int, fifo_rdata, rx_count);
  modport ctl (output csr_wr, csr_wdata, fifo_rd, fifo_wr, fifo_wdata, function_address_reg_wr, function_address_reg,
               input csr_rdata, ep0_int, fifo_rdata, rx_count);
endinterface : ep0_link_if
`default_nettype wire

/* logic/ep0_pkg.sv */
// Shared constants and types for the endpoint 0 control handler
package ep0_pkg;

  // ----------------------------------------------------------------
  // Endpoint 0 sizes
  // ----------------------------------------------------------------
  localparam logic [6:0] EP0_MPS       = 7'h40; // max_packet_size in bytes
  localparam logic [6:0] EP0_SETUP_LEN = 7'h08; // command length of a request
  localparam logic [6:0] EP0_CNT_SAT   = 7'h7F; // byte counter saturates here
  localparam int         EP0_REQ_TYPE  = 0;     // command byte holding direction
  localparam int         EP0_DIR_BIT   = 7;     // direction bit, 1 = IN
  localparam int         EP0_WLEN_LO   = 6;     // data length, low byte
  localparam int         EP0_WLEN_HI   = 7;     // data length, high byte

  // ----------------------------------------------------------------
  // ep0_control_status bit positions
  // ----------------------------------------------------------------
  localparam int B_RXR   = 0; // rx_packet_ready
  localparam int B_TXR   = 1; // tx_packet_ready
  localparam int B_SSENT = 2; // stall_sent_flag
  localparam int B_DEND  = 3; // data_phase_last
  localparam int B_PEND  = 4; // premature_end_flag
  localparam int B_SREQ  = 5; // stall_request
  localparam int B_SERV  = 6; // rx_packet_serviced
  localparam int B_PCLR  = 7; // premature_end_clear
  localparam logic [7:0] CSR_PCLR_ONLY = 8'h80;

  // ----------------------------------------------------------------
  // Host side codes and modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PID_SETUP = 2'h0, PID_OUT = 2'h1, PID_IN = 2'h2} ep0_pid_e;
  typedef enum logic [1:0] {HS_ACK = 2'h0, HS_NAK = 2'h1, HS_STALL = 2'h2} ep0_hs_e;
  typedef enum logic [1:0] {MODE_IDLE = 2'h0, MODE_TX = 2'h1, MODE_RX = 2'h2} ep0_mode_e;

  // ----------------------------------------------------------------
  // Controller register map (AXI4-Lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_FIFO  = 8'h08;
  localparam logic [7:0] A_CNT   = 8'h0C;
  localparam logic [7:0] A_FUNCTION_ADDRESS_REG = 8'h10;
  localparam int         F_MODE_LO = 8;  // mode field in CMD and STAT
  localparam int         F_MODE_HI = 9;
  localparam int         F_EVT     = 10; // sticky event bit in STAT
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ep0_pkg

/* tb/ep0_link_asserts.sv */
// Concurrent checks on the endpoint 0 link between core and controller
`timescale 1ns/1ps
`default_nettype none
module ep0_link_asserts
  import ep0_pkg::*;
(
  // Clock and reset
  input  wire logic       I_REF_CLK,
  input  wire logic       I_RST_B,
  // Link signals
  input  wire logic       csr_wr,
  input  wire logic [7:0] csr_wdata,
  input  wire logic [7:0] csr_rdata,
  input  wire logic       ep0_int
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  // ----------------------------------------------------------------
  // Core events that must come with an interrupt
  // ----------------------------------------------------------------
  a_rxr_int: assert property ($rose(csr_rdata[B_RXR]) |-> ep0_int)
    else $error("rx ready set without interrupt");
  a_txr_int: assert property ($fell(csr_rdata[B_TXR]) |-> ep0_int)
    else $error("tx ready cleared without interrupt");
  a_stall_int: assert property ($rose(csr_rdata[B_SSENT]) |-> ep0_int)
    else $error("stall sent without interrupt");
  a_pend_int: assert property ($rose(csr_rdata[B_PEND]) |-> ep0_int)
    else $error("premature end without interrupt");
  // ----------------------------------------------------------------
  // Controller writes take effect; a same-cycle core event may win
  // ----------------------------------------------------------------
  a_sreq_set: assert property (csr_wr && csr_wdata[B_SREQ] |-> ##[1:2] (csr_rdata[B_SREQ] || ep0_int))
    else $error("stall request not taken");
  a_dend_set: assert property (csr_wr && csr_wdata[B_DEND] |-> ##[1:2] (csr_rdata[B_DEND] || ep0_int))
    else $error("data last not taken");
  a_txr_set: assert property (csr_wr && csr_wdata[B_TXR] |-> ##[1:2] (csr_rdata[B_TXR] || ep0_int))
    else $error("tx ready not taken");
  a_serv_clr: assert property (csr_wr && csr_wdata[B_SERV] |-> ##[1:2] (!csr_rdata[B_RXR] || ep0_int))
    else $error("serviced did not clear rx ready");
  a_pend_clr: assert property (csr_wr && csr_wdata[B_PCLR] |-> ##[1:2] (!csr_rdata[B_PEND] || ep0_int))
    else $error("premature end not cleared");
  a_high_zero: assert property (csr_rdata[7:6] == 2'b00)
    else $error("write-only status bits read back set");
  a_reset_idle: assert property ($rose(I_RST_B) |-> csr_rdata == 8'h00 && !ep0_int)
    else $error("status not idle after reset");
  // Main scenarios reached
  c_tx_done: cover property ($fell(csr_rdata[B_TXR]));
  c_stall: cover property ($rose(csr_rdata[B_SSENT]));
  c_pend: cover property ($rose(csr_rdata[B_PEND]));
endmodule : ep0_link_asserts
`default_nettype wire

/* tb/usb_device_ep0_control_handler_bench.sv */
// Self-checking bench: controller over AXI4-Lite, core driven as a host
`timescale 1ns/1ps
`default_nettype none
module usb_device_ep0_control_handler_bench import ep0_pkg::*;;
  localparam int LIM = 400;
  logic clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
  logic rready = 1'b0, tokv = 1'b0, rxv = 1'b0, rxe = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rxd = 8'h00;
  logic [1:0] pid = 2'h0, hs_last = 2'h3, rsp_q;
  logic [31:0] wdata = 32'h0, rd_q;
  logic awr, wr_rdy, bv, arr, rv, hsv, txv, txe;
  logic [1:0] bresp, rresp, hsc;
  logic [31:0] rdata;
  logic [7:0] txd, byte_q[$], txq[$];
  logic [6:0] fad;
  int num_errors = 0, cmp_count = 0, int_cnt = 0;
  ep0_link_if link ();
  ep0_core i_ep0_core (.I_REF_CLK(clk), .I_RST_B(rst_b), .LINK(link), .I_TOK_VALID(tokv),
    .I_TOK_PID(pid), .I_RX_VALID(rxv), .I_RX_DATA(rxd), .I_RX_END(rxe), .O_HS_VALID(hsv),
    .O_HS_CODE(hsc), .O_TX_VALID(txv), .O_TX_DATA(txd), .O_TX_END(txe), .O_FUNC_ADDR(fad));
  ep0_ctl i_ep0_ctl (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_AWVALID(awv), .I_AWADDR(awaddr),
    .O_AWREADY(awr), .I_WVALID(wv), .I_WDATA(wdata), .I_WSTRB(4'hF), .O_WREADY(wr_rdy),
    .O_BVALID(bv), .O_BRESP(bresp), .I_BREADY(bready), .I_ARVALID(arv), .I_ARADDR(araddr),
    .O_ARREADY(arr), .O_RVALID(rv), .O_RDATA(rdata), .O_RRESP(rresp), .I_RREADY(rready),
    .LINK(link));
  ep0_link_asserts i_ep0_link_asserts (.I_REF_CLK(clk), .I_RST_B(rst_b), .csr_wr(link.csr_wr),
    .csr_wdata(link.csr_wdata), .csr_rdata(link.csr_rdata), .ep0_int(link.ep0_int));
  // ----------------------------------------------------------------
  // Clock and host-side monitor
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  // Host events logged; EE marks a packet end
  always @(posedge clk)
  begin
    if (hsv) hs_last <= hsc;
    if (txv || txe) txq.push_back(txe ? 8'hEE : txd);
    if (link.ep0_int) int_cnt <= int_cnt + 1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("Compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  // A used-up wait bound ends the run as a failure
  task automatic guard(input int n);
    if (n >= LIM)
    begin
      num_errors++;
      summarize();
    end
  endtask : guard
  // Address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (!bv && n < LIM);
    bready <= 1'b0;
    rsp_q = bresp;
    guard(n);
    @(posedge clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < LIM);
    rd_q = rdata;
    rsp_q = rresp;
    guard(n);
  endtask : axi_rd
  // Token, bytes, end; waits for the interrupt
  task automatic host_pkt(input logic [1:0] p, input logic dat);
    int n0, n;
    n0 = int_cnt;
    n = 0;
    tokv <= 1'b1;
    pid <= p;
    @(posedge clk);
    tokv <= 1'b0;
    if (dat)
    begin
      foreach (byte_q[i])
      begin
        rxv <= 1'b1;
        rxd <= byte_q[i];
        @(posedge clk);
      end
      rxv <= 1'b0;
      rxe <= 1'b1;
      @(posedge clk);
      rxe <= 1'b0;
    end
    while (int_cnt == n0 && n < LIM)
    begin
      @(posedge clk);
      n++;
    end
    guard(n);
    @(posedge clk);
  endtask : host_pkt
  // Event bit, mode, masked flags; event then cleared
  task automatic stat_chk(input logic [7:0] m, input logic [7:0] e, input logic [1:0] md);
    axi_rd(A_STAT);
    chk(rd_q[10:0] & {3'h7, m}, {1'b1, md, e});
    axi_wr(A_STAT, 32'h0000_0400);
  endtask : stat_chk
  task automatic setup(input logic [7:0] rt, input logic [7:0] wl);
    byte_q = {rt, 8'h05, 8'h12, 8'h00, 8'h00, 8'h00, wl, 8'h00};
    host_pkt(PID_SETUP, 1'b1);
    chk(hs_last, HS_ACK);
    stat_chk(8'h3F, 8'h01, MODE_IDLE);
    foreach (byte_q[i])
    begin
      axi_rd(A_FIFO);
      chk(rd_q[7:0], byte_q[i]);
    end
  endtask : setup
  task automatic stall_chk(input logic [7:0] m);
    chk(hs_last, HS_STALL);
    stat_chk(m, 8'h04, MODE_IDLE);
    axi_wr(A_CMD, 32'h0000_0004);
  endtask : stall_chk
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    axi_rd(A_STAT);
    chk(rd_q, 32'h0);
    axi_rd(8'h14);
    chk({rsp_q, rd_q[29:0]}, {RESP_SLVERR, 30'h0});
    axi_wr(8'h14, 32'h1);
    chk(rsp_q, RESP_SLVERR);
    // Zero-data request, address, status stage
    setup(8'h00, 8'h00);
    axi_wr(A_FUNCTION_ADDRESS_REG, 32'h12);
    chk(fad, 7'h12);
    axi_wr(A_CMD, 32'h48);
    axi_rd(A_STAT);
    chk(rd_q[5:0], 6'h08);
    txq.delete();
    host_pkt(PID_IN, 1'b0);
    chk({8'(txq.size()), txq[0]}, 16'h01EE);
    stat_chk(8'h00, 8'h00, MODE_IDLE);
    // Read request, then one IN too many
    setup(8'h80, 8'h02);
    axi_wr(A_CMD, 32'h140);
    axi_wr(A_FIFO, 32'hA5);
    axi_wr(A_FIFO, 32'h5A);
    axi_wr(A_CMD, 32'h10A);
    txq.delete();
    host_pkt(PID_IN, 1'b0);
    chk({8'(txq.size()), txq[0], txq[1], txq[2]}, 32'h03A55AEE);
    stat_chk(8'h02, 8'h00, MODE_TX);
    host_pkt(PID_IN, 1'b0);
    stall_chk(8'h06);
    // Refused write request
    setup(8'h00, 8'h04);
    axi_wr(A_CMD, 32'h60);
    host_pkt(PID_OUT, 1'b0);
    stall_chk(8'h24);
    // Write request, one packet, then OUT past the end
    setup(8'h00, 8'h04);
    axi_wr(A_CMD, 32'h240);
    byte_q = {8'h11, 8'h22, 8'h33, 8'h44};
    host_pkt(PID_OUT, 1'b1);
    chk(hs_last, HS_ACK);
    axi_rd(A_CNT);
    chk(rd_q[6:0], 7'h04);
    stat_chk(8'h01, 8'h01, MODE_RX);
    axi_wr(A_CMD, 32'h48);
    host_pkt(PID_OUT, 1'b0);
    stall_chk(8'h04);
    // OUT during an open read request
    setup(8'h80, 8'h02);
    axi_wr(A_CMD, 32'h140);
    host_pkt(PID_OUT, 1'b0);
    chk(hs_last, HS_NAK);
    stat_chk(8'h00, 8'h00, MODE_IDLE);
    axi_rd(A_STAT);
    chk(rd_q[4], 1'b0);
    summarize();
  end
endmodule : usb_device_ep0_control_handler_bench
`default_nettype wire
